// >>> pkg/regs_pkg.sv
// constants shared by the serial control port and its register store
// assumes one 100 MHz core clock; serial pins are sampled, never used as clocks

package regs_pkg;

   // data and address shape
   localparam int          DATA_W        = 8;
   localparam int          ADDR_W        = 7;
   localparam int          BYTE_BITS     = 8;
   localparam int          PAGE_SIZE     = 128;
   localparam int          NUM_PAGES     = 3;

   // page selector, present at offset 0 of every page
   localparam logic [6:0]  PAGE_REG_ADDR = 7'h00;
   localparam logic [7:0]  PAGE_RESET    = 8'h00;

   // pages that hold storage and their slot in the memory
   localparam logic [7:0]  PAGE_A        = 8'h00;
   localparam logic [7:0]  PAGE_B        = 8'h01;
   localparam logic [7:0]  PAGE_C        = 8'h03;
   localparam logic [1:0]  SLOT_A        = 2'h0;
   localparam logic [1:0]  SLOT_B        = 2'h1;
   localparam logic [1:0]  SLOT_C        = 2'h2;
   localparam logic [1:0]  SLOT_NONE     = 2'h3;

   // command byte layout
   localparam int          CMD_RW_BIT    = 0;
   localparam logic [2:0]  LAST_BIT      = 3'h7;

   // two-wire target address, upper five bits fixed, lower two from strap
   localparam logic [4:0]  TW_ADDR_HI    = 5'h14;
   localparam logic [3:0]  TW_BYTE_DONE  = 4'h8;

   // reset level of the sampled pins: mode, strap(2), clock, data, select
   localparam logic [5:0]  PIN_RESET     = 6'h0D;

endpackage

// >>> pkg/reg_port_if.sv
// register access port between the serial front end and the register store
// assumes both ends run on the same core clock
`timescale 1ns/1ps

interface reg_port_if;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic       we;
   logic       soft_rst;
   logic [7:0] rdata;
   logic [7:0] page;

   modport ctrl  (output addr, output wdata, output we, output soft_rst,
                  input rdata, input page);
   modport store (input addr, input wdata, input we, input soft_rst,
                  output rdata, output page);
endinterface

// >>> core/pin_sync.sv
// two-stage synchroniser for a group of pins
// assumes the pins are asynchronous to clk; only q may be read by logic
`timescale 1ns/1ps

module pin_sync #(
   parameter int            W   = 1,
   parameter logic [W-1:0]  RST = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         ce,
   // pins in, synchronised out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= RST;
         q        <= RST;
      end else if (ce) begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule

// >>> core/reg_memory.sv
// paged register store: page selector plus three pages of 128 bytes
// assumes one write per cycle; read data registered, one cycle behind addr
`timescale 1ns/1ps

module reg_memory #(
   parameter int ROWS  = regs_pkg::PAGE_SIZE,
   parameter int PAGES = regs_pkg::NUM_PAGES
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ce,
   // register port
   reg_port_if.store rp
);
   import regs_pkg::*;

   logic [7:0] mem [0:ROWS*PAGES-1];
   logic [1:0] slot;

   // unbacked pages map to no slot: storage reads give zero, storage writes are dropped
   function automatic logic [1:0] page_slot(input logic [7:0] p);
      case (p)
         PAGE_A:  page_slot = SLOT_A;
         PAGE_B:  page_slot = SLOT_B;
         PAGE_C:  page_slot = SLOT_C;
         default: page_slot = SLOT_NONE;
      endcase
   endfunction

   assign slot = page_slot(rp.page);

   ////////////////////////////////////////////////////////////////////////////
   // page selector

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rp.page <= PAGE_RESET;
      end else if (ce) begin
         if (rp.soft_rst) begin
            rp.page <= PAGE_RESET;
         end else if (rp.we && rp.addr == PAGE_REG_ADDR) begin
            rp.page <= rp.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // storage, no reset so it maps onto a ram

   always_ff @(posedge clk) begin
      if (ce && rp.we && rp.addr != PAGE_REG_ADDR && slot != SLOT_NONE) begin
         mem[{slot, rp.addr}] <= rp.wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rp.rdata <= 8'h00;
      end else if (ce) begin
         if (rp.addr == PAGE_REG_ADDR) begin
            rp.rdata <= rp.page;
         end else if (page_slot(rp.page) == SLOT_NONE) begin
            rp.rdata <= 8'h00;
         end else begin
            rp.rdata <= mem[{slot, rp.addr}];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   page_reset_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && rp.soft_rst) |=> rp.page == PAGE_RESET)
      else $error("page not cleared by software reset");

   page_write_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && rp.we && rp.addr == PAGE_REG_ADDR && !rp.soft_rst)
      |=> rp.page == $past(rp.wdata))
      else $error("page selector write not taken");

   reserved_read_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && rp.addr != PAGE_REG_ADDR && page_slot(rp.page) == SLOT_NONE)
      |=> rp.rdata == 8'h00)
      else $error("unbacked page did not read zero");

endmodule

// >>> core/serial_ctrl.sv
// serial control port: four-wire and two-wire target into a paged register store
// assumes pins asynchronous to clk; serial clock well below clk/4
`timescale 1ns/1ps

module serial_ctrl (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         nrst,
   input  wire logic                         ce,
   // straps and software reset
   input  wire logic                         spi_mode,
   input  wire logic [1:0]                   addr_strap,
   input  wire logic                         sw_reset,
   // serial pins
   input  wire logic                         sclk_scl,
   input  wire logic                         pico_sda,
   input  wire logic                         chip_select_n,
   // two-wire data drive, open drain
   output logic                              sda_out,
   output logic                              sda_oe,
   // four-wire data out
   output logic                              poci_out,
   output logic                              poci_oe,
   // current page
   output logic [regs_pkg::DATA_W-1:0]       page_sel
);
   import regs_pkg::*;

   typedef enum logic [1:0] {spi_idle, spi_cmd, spi_data} spi_state_e;
   typedef enum logic [3:0] {tw_idle, tw_dev, tw_dev_ack, tw_reg, tw_reg_ack,
                             tw_wr, tw_wr_ack, tw_rd, tw_rd_ack} tw_state_e;

   reg_port_if rp ();

   logic [5:0]  pins_s;
   logic        mode_s;
   logic [1:0]  strap_s;
   logic        clk_s;
   logic        dat_s;
   logic        csn_s;
   logic        clk_d;
   logic        dat_d;
   logic        csn_d;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_fall;
   logic        spi_act;
   logic        tw_start;
   logic        tw_stop;
   logic        tw_busy;

   spi_state_e  spi_state;
   logic [2:0]  bit_cnt;
   logic [7:0]  rx_sh;
   logic [7:0]  rx_byte;
   logic [7:0]  tx_sh;
   logic        read_not_write_flag;
   logic        byte_end;
   logic        spi_cmd_done;
   logic        spi_data_done;
   logic        tx_load;

   tw_state_e   tw_state;
   logic [3:0]  tw_cnt;
   logic [7:0]  tw_sh;
   logic [7:0]  tw_byte;
   logic [7:0]  tw_tx;
   logic        tw_rnw;
   logic        tw_ack;
   logic        tw_byte_end;
   logic        tw_reg_done;
   logic        tw_wr_done;
   logic        tw_rd_acked;

   logic [6:0]  reg_addr;

   ////////////////////////////////////////////////////////////////////////////
   // pin sampling and edge detection

   pin_sync #(.W(6), .RST(PIN_RESET)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .ce   (ce),
      .d    ({spi_mode, addr_strap, sclk_scl, pico_sda, chip_select_n}),
      .q    (pins_s)
   );

   assign {mode_s, strap_s, clk_s, dat_s, csn_s} = pins_s;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // match the synchroniser reset so no false edge follows reset
         clk_d <= PIN_RESET[2];
         dat_d <= PIN_RESET[1];
         csn_d <= PIN_RESET[0];
      end else if (ce) begin
         clk_d <= clk_s;
         dat_d <= dat_s;
         csn_d <= csn_s;
      end
   end

   // four-wire clock idles low: rise launches data, fall samples it; two-wire samples on rise, drives on fall
   assign sclk_rise = clk_s & ~clk_d;
   assign sclk_fall = ~clk_s & clk_d;
   assign cs_fall   = ~csn_s & csn_d;
   assign spi_act   = mode_s & ~csn_s;
   assign tw_start  = clk_s & clk_d & dat_d & ~dat_s;
   assign tw_stop   = clk_s & clk_d & ~dat_d & dat_s;
   assign tw_busy   = ~mode_s & ~tw_start & ~tw_stop;

   ////////////////////////////////////////////////////////////////////////////
   // four-wire receive and framing

   assign rx_byte       = {rx_sh[6:0], dat_s};
   assign byte_end      = spi_act & ~cs_fall & sclk_fall & (spi_state != spi_idle)
                          & (bit_cnt == LAST_BIT);
   assign spi_cmd_done  = byte_end & (spi_state == spi_cmd);
   assign spi_data_done = byte_end & (spi_state == spi_data);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         spi_state           <= spi_idle;
         bit_cnt             <= 3'h0;
         rx_sh               <= 8'h00;
         read_not_write_flag <= 1'b0;
      end else if (ce) begin
         if (!spi_act) begin
            spi_state <= spi_idle;
            bit_cnt   <= 3'h0;
         end else if (cs_fall) begin
            spi_state <= spi_cmd;
            bit_cnt   <= 3'h0;
         end else if (sclk_fall && spi_state != spi_idle) begin
            rx_sh   <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (spi_cmd_done) begin
               spi_state           <= spi_data;
               read_not_write_flag <= rx_byte[CMD_RW_BIT];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // four-wire transmit; data-out driven only through read data bytes

   assign tx_load = spi_act & ~cs_fall & sclk_rise & (spi_state == spi_data)
                    & read_not_write_flag & (bit_cnt == 3'h0);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_sh    <= 8'h00;
         poci_out <= 1'b0;
         poci_oe  <= 1'b0;
      end else if (ce) begin
         if (!spi_act || spi_state != spi_data || !read_not_write_flag) begin
            poci_oe <= 1'b0;
         end else if (tx_load) begin
            poci_out <= rp.rdata[7];
            tx_sh    <= {rp.rdata[6:0], 1'b0};
            poci_oe  <= 1'b1;
         end else if (sclk_rise) begin
            poci_out <= tx_sh[7];
            tx_sh    <= {tx_sh[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-wire target

   assign tw_byte     = {tw_sh[6:0], dat_s};
   assign tw_byte_end = tw_busy & sclk_fall & (tw_cnt == TW_BYTE_DONE);
   assign tw_reg_done = tw_byte_end & (tw_state == tw_reg);
   assign tw_wr_done  = tw_byte_end & (tw_state == tw_wr);
   assign tw_rd_acked = tw_busy & sclk_rise & ~dat_s & (tw_state == tw_rd_ack);
   assign sda_out     = 1'b0;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tw_state <= tw_idle;
         tw_cnt   <= 4'h0;
         tw_sh    <= 8'h00;
         tw_tx    <= 8'h00;
         tw_rnw   <= 1'b0;
         tw_ack   <= 1'b0;
         sda_oe   <= 1'b0;
      end else if (ce) begin
         if (mode_s || tw_stop) begin
            tw_state <= tw_idle;
            sda_oe   <= 1'b0;
         end else if (tw_start) begin
            tw_state <= tw_dev;
            tw_cnt   <= 4'h0;
            sda_oe   <= 1'b0;
         end else begin
            case (tw_state)
               tw_dev, tw_reg, tw_wr: begin
                  if (sclk_rise) begin
                     tw_sh  <= tw_byte;
                     tw_cnt <= tw_cnt + 4'h1;
                  end else if (tw_byte_end) begin
                     tw_cnt <= 4'h0;
                     sda_oe <= 1'b1;
                     if (tw_state == tw_reg) begin
                        tw_state <= tw_reg_ack;
                     end else if (tw_state == tw_wr) begin
                        tw_state <= tw_wr_ack;
                     end else if (tw_sh[7:1] == {TW_ADDR_HI, strap_s}) begin
                        tw_rnw   <= tw_sh[0];
                        tw_state <= tw_dev_ack;
                     end else begin
                        sda_oe   <= 1'b0;
                        tw_state <= tw_idle;
                     end
                  end
               end
               tw_dev_ack, tw_reg_ack, tw_wr_ack: begin
                  if (sclk_fall) begin
                     if (tw_state == tw_dev_ack && tw_rnw) begin
                        sda_oe   <= ~rp.rdata[7];
                        tw_tx    <= {rp.rdata[6:0], 1'b0};
                        tw_state <= tw_rd;
                     end else begin
                        sda_oe   <= 1'b0;
                        tw_state <= (tw_state == tw_dev_ack) ? tw_reg : tw_wr;
                     end
                  end
               end
               tw_rd: begin
                  if (sclk_rise) begin
                     tw_cnt <= tw_cnt + 4'h1;
                  end else if (sclk_fall) begin
                     if (tw_cnt == TW_BYTE_DONE) begin
                        sda_oe   <= 1'b0;
                        tw_cnt   <= 4'h0;
                        tw_state <= tw_rd_ack;
                     end else begin
                        sda_oe <= ~tw_tx[7];
                        tw_tx  <= {tw_tx[6:0], 1'b0};
                     end
                  end
               end
               tw_rd_ack: begin
                  if (sclk_rise) begin
                     tw_ack <= ~dat_s;
                  end else if (sclk_fall) begin
                     if (tw_ack) begin
                        sda_oe   <= ~rp.rdata[7];
                        tw_tx    <= {rp.rdata[6:0], 1'b0};
                        tw_state <= tw_rd;
                     end else begin
                        tw_state <= tw_idle;
                     end
                  end
               end
               default: tw_state <= tw_idle;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register address and write strobe

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_addr <= 7'h00;
      end else if (ce) begin
         if (spi_cmd_done) begin
            reg_addr <= rx_byte[7:1];
         end else if (spi_data_done) begin
            reg_addr <= reg_addr + 7'h1;
         end else if (tw_reg_done) begin
            reg_addr <= tw_sh[6:0];
         end else if (tw_wr_done || tw_rd_acked) begin
            reg_addr <= reg_addr + 7'h1;
         end
      end
   end

   assign rp.addr     = reg_addr;
   assign rp.wdata    = mode_s ? rx_byte : tw_sh;
   assign rp.we       = ce & ((spi_data_done & ~read_not_write_flag) | tw_wr_done);
   assign rp.soft_rst = sw_reset;
   assign page_sel    = rp.page;

   reg_memory u_mem (
      .clk  (clk),
      .nrst (nrst),
      .ce   (ce),
      .rp   (rp.store)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks

   poci_idle_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && !spi_act) |=> !poci_oe)
      else $error("data-out driven with select high");

   cmd_addr_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && spi_cmd_done) |=> reg_addr == $past(rx_byte[7:1]))
      else $error("command address not taken");

   wr_dir_a: assert property (@(posedge clk) disable iff (!nrst)
      (rp.we && mode_s) |-> !read_not_write_flag)
      else $error("write strobe during read frame");

   spi_step_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && spi_data_done) |=> reg_addr == $past(reg_addr) + 7'h1)
      else $error("address did not advance after data byte");

   poci_msb_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && tx_load) |=> poci_oe && poci_out == $past(rp.rdata[7]))
      else $error("read data msb not presented first");

   poci_edge_a: assert property (@(posedge clk) disable iff (!nrst)
      !$stable(poci_out) |-> $past(sclk_rise && ce))
      else $error("data-out changed away from rising clock");

   tw_step_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && tw_rd_acked) |=> reg_addr == $past(reg_addr) + 7'h1)
      else $error("two-wire read did not advance on ack");

   tw_release_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && !mode_s && tw_stop) |=> !sda_oe ##1 !sda_oe)
      else $error("data line held after stop");

endmodule

// >>> verification/spi_host_model.sv
// host model: four-wire frames on clock, select and data-in, two-wire reads on the same pins
// assumes the device answers well inside half a serial period
`timescale 1ns/1ps

module spi_host_model #(
   parameter real HALF = 62.5
) (
   // returned data
   input  wire logic       poci_out,
   input  wire logic       poci_oe,
   // device pull on the shared data line, pulled up otherwise
   input  wire logic       sda_oe,
   // host driven pins
   output logic            sclk,
   output logic            pico,
   output logic            chip_select_n,
   // last byte seen on the return line
   output logic [7:0]      rx_byte
);
   event rx_done;
   logic last_bit;

   initial begin
      sclk          = 1'b0;
      pico          = 1'b0;
      chip_select_n = 1'b1;
      rx_byte       = 8'h00;
      last_bit      = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // extra 1 ns keeps pin changes off the core clock edge
   task automatic start_frame();
      #(HALF + 1.0) chip_select_n = 1'b0;
      #(HALF);
   endtask

   // select held low until every byte is out, then raised
   task automatic end_frame();
      #(HALF) chip_select_n = 1'b1;
      pico = ~pico;
      #(HALF);
   endtask

   // clock pulses with select high; the device must ignore them
   task automatic stray(input int n);
      #1;
      for (int i = 0; i < n; i++) begin
         #(HALF) sclk = 1'b1;
         pico = ~pico;
         #(HALF) sclk = 1'b0;
      end
   endtask

   task automatic xfer(input logic [7:0] tx);
      logic [7:0] rx;
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b1;
         pico = tx[i];
         #(HALF) sclk = 1'b0;
         // released line reads as the inverse of its last level, never a stale copy
         rx[i] = poci_oe ? poci_out : ~last_bit;
         last_bit = rx[i];
         #(HALF);
      end
      rx_byte = rx;
      -> rx_done;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // two-wire bit: data moves mid-low, sampled mid-high on the wired line
   task automatic tw_bit(input logic b, output logic s);
      #(HALF / 2) pico = b;
      #(HALF / 2) sclk = 1'b1;
      #(HALF / 2) s = pico & ~sda_oe;
      #(HALF / 2) sclk = 1'b0;
   endtask

   // start or repeated start: data falls while the clock is high
   task automatic tw_open();
      #(HALF / 2 + 1.0) pico = 1'b1;
      #(HALF / 2) sclk = 1'b1;
      #(HALF) pico = 1'b0;
      #(HALF) sclk = 1'b0;
   endtask

   // stop: data rises while the clock is high, both lines left idle high
   task automatic tw_close();
      #(HALF / 2) pico = 1'b0;
      #(HALF / 2) sclk = 1'b1;
      #(HALF) pico = 1'b1;
      #(HALF);
   endtask

   task automatic tw_send(input logic [7:0] tx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) tw_bit(tx[i], s);
      tw_bit(1'b1, s);
      ack = ~s;
   endtask

   // ack keeps the device streaming, nack ends the read
   task automatic tw_recv(input logic ack);
      logic [7:0] rx;
      logic       s;
      for (int i = 7; i >= 0; i--) tw_bit(1'b1, rx[i]);
      tw_bit(~ack, s);
      rx_byte = rx;
      -> rx_done;
   endtask
endmodule

// >>> verification/serial_ctrl_tb.sv
// self-checking bench for the serial control port in four-wire and two-wire mode
// assumes the host model file is compiled first
`timescale 1ns/1ps

module serial_ctrl_tb;
   import regs_pkg::*;
   typedef struct packed { logic care; logic [7:0] val; } note_s;

   logic       clk, nrst, sw_reset, sclk, pico, chip_select_n;
   logic       sda_out, sda_oe, poci_out, poci_oe;
   logic       spi_mode, sda_wire, ack;
   logic [7:0] page_sel, rx_byte, cur_page;
   logic [7:0] mem [logic [14:0]];
   logic [7:0] pg_list [4] = '{PAGE_B, PAGE_C, 8'h02, PAGE_A};
   note_s      notes [$];
   int         n_mismatch, checked;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // pulled-up data line: host or device may pull it low
   assign sda_wire = pico & ~sda_oe;

   serial_ctrl serial_ctrl_inst (.clk(clk), .nrst(nrst), .ce(1'b1), .spi_mode(spi_mode),
      .addr_strap(2'h0), .sw_reset(sw_reset), .sclk_scl(sclk), .pico_sda(sda_wire),
      .chip_select_n(chip_select_n), .sda_out(sda_out), .sda_oe(sda_oe),
      .poci_out(poci_out), .poci_oe(poci_oe), .page_sel(page_sel));

   spi_host_model spi_host_model_inst (.poci_out(poci_out), .poci_oe(poci_oe),
      .sda_oe(sda_oe), .sclk(sclk),
      .pico(pico), .chip_select_n(chip_select_n), .rx_byte(rx_byte));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      if (notes.size() != 0) n_mismatch++;
      if (n_mismatch == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // reference view of the paged store; unbacked pages hold nothing
   function automatic logic [7:0] exp_rd(input logic [6:0] a);
      if (a == PAGE_REG_ADDR) return cur_page;
      if (!(cur_page inside {PAGE_A, PAGE_B, PAGE_C})) return 8'h00;
      return mem[{cur_page, a}];
   endfunction

   task automatic exp_wr(input logic [6:0] a, input logic [7:0] d);
      if (a == PAGE_REG_ADDR) cur_page = d;
      else if (cur_page inside {PAGE_A, PAGE_B, PAGE_C}) mem[{cur_page, a}] = d;
   endtask

   // one framed transfer: command byte, then n data bytes at rising addresses
   task automatic frame(input logic [6:0] a, input logic rd, input int n, input int fix = -1);
      logic [7:0] d;
      spi_host_model_inst.start_frame();
      notes.push_back('{1'b0, 8'h00});
      spi_host_model_inst.xfer({a, rd});
      for (int i = 0; i < n; i++) begin
         d = (fix < 0) ? 8'($urandom()) : fix[7:0];
         if (rd) begin
            notes.push_back('{1'b1, exp_rd(7'(a + i))});
         end else begin
            notes.push_back('{1'b0, 8'h00});
            exp_wr(7'(a + i), d);
         end
         spi_host_model_inst.xfer(d);
      end
      spi_host_model_inst.end_frame();
      repeat (6) @(posedge clk);
      cmp("poci_oe", 8'h00, {7'h00, poci_oe});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(spi_host_model_inst.rx_done) begin
      note_s n;
      if (notes.size() == 0) begin
         n_mismatch++;
         $display("CHECK FAILED byte_count expected %h seen %h", 8'h00, 8'h01);
      end else begin
         n = notes.pop_front();
         if (n.care) cmp("read_data", n.val, rx_byte);
      end
   end

   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      n_mismatch = 0;
      checked    = 0;
      cur_page   = PAGE_RESET;
      nrst       = 1'b0;
      sw_reset   = 1'b0;
      spi_mode   = 1'b1;
      void'($urandom(32'h3cf8210c));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      cmp("page_sel", PAGE_RESET, page_sel);
      frame(PAGE_REG_ADDR, 1'b1, 1);
      // stray clocks before the select fall must not shift the command
      spi_host_model_inst.stray(3);
      frame(7'h01, 1'b0, 5);
      frame(7'h01, 1'b1, 5);
      foreach (pg_list[k]) begin
         frame(PAGE_REG_ADDR, 1'b0, 1, int'(pg_list[k]));
         cmp("page_sel", pg_list[k], page_sel);
         if (pg_list[k] != 8'h02) frame(PAGE_REG_ADDR, 1'b1, 1);
         frame(7'h7D, 1'b0, 3);
         frame(7'h7D, 1'b1, 3);
      end
      // page 0 contents must survive traffic on the other pages
      frame(7'h01, 1'b1, 5);
      frame(PAGE_REG_ADDR, 1'b0, 1, int'(PAGE_C));
      @(posedge clk);
      sw_reset <= 1'b1;
      @(posedge clk);
      sw_reset <= 1'b0;
      cur_page = PAGE_RESET;
      repeat (3) @(posedge clk);
      cmp("page_sel", PAGE_RESET, page_sel);
      frame(7'h01, 1'b1, 2);
      // two-wire multi-byte read from register 1 of page 0
      spi_mode <= 1'b0;
      repeat (6) @(posedge clk);
      spi_host_model_inst.tw_open();
      spi_host_model_inst.tw_send({TW_ADDR_HI, 2'h0, 1'b0}, ack);
      cmp("tw_ack", 8'h01, {7'h00, ack});
      spi_host_model_inst.tw_send(8'h01, ack);
      cmp("tw_ack", 8'h01, {7'h00, ack});
      spi_host_model_inst.tw_open();
      spi_host_model_inst.tw_send({TW_ADDR_HI, 2'h0, 1'b1}, ack);
      cmp("tw_ack", 8'h01, {7'h00, ack});
      for (int i = 0; i < 3; i++) begin
         notes.push_back('{1'b1, exp_rd(7'(1 + i))});
         spi_host_model_inst.tw_recv(i < 2);
      end
      spi_host_model_inst.tw_close();
      repeat (6) @(posedge clk);
      cmp("sda_oe", 8'h00, {7'h00, sda_oe});
      cmp("sda_out", 8'h00, {7'h00, sda_out});
      report_and_stop();
   end
endmodule
